// file: core/rml_led_driver.sv
// Purpose: Status lamp driver for an agent release module
// Assumes: Condition inputs synchronous to clock; AHB-Lite single slave
// Notes:   Zero-wait slave; CTRL adds a software isolate request
`timescale 1ns/10ps
module rml_led_driver #(
  parameter int TICK_CYCLES = rml_pkg::TICK_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Module conditions
  input  wire rml_pkg::rml_cond_t    cond,
  // Lamps
  output rml_pkg::rml_lamp_t         lamp,
  // Register bus
  input  wire rml_pkg::rml_ahb_req_t ahb_req,
  output rml_pkg::rml_ahb_rsp_t      ahb_rsp
);
  import rml_pkg::*;

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  // ----------------------------------------------------------------------
  // Blink timebase
  // ----------------------------------------------------------------------
  logic [TW-1:0] div_cnt;
  logic [TW-1:0] next_div_cnt;
  logic          tick;
  logic          next_tick;
  logic          blink_trouble;
  logic          blink_iso;
  logic          blink_reliso;

  always_comb begin
    next_div_cnt = div_cnt + TW'(1);
    next_tick    = 1'b0;
    if (div_cnt == TW'(TICK_CYCLES - 1)) begin
      next_div_cnt = '0;
      next_tick    = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

  // Common tick keeps the two 1 Hz patterns in phase
  rml_blink #(.PERIOD(TROUBLE_PER_TICKS), .ON(TROUBLE_ON_TICKS)) u_trouble (
    .clock (clock),
    .rst   (rst),
    .tick  (tick),
    .level (blink_trouble)
  );

  rml_blink #(.PERIOD(ISO_PER_TICKS), .ON(ISO_ON_TICKS)) u_iso (
    .clock (clock),
    .rst   (rst),
    .tick  (tick),
    .level (blink_iso)
  );

  rml_blink #(.PERIOD(ISO_PER_TICKS), .ON(RELISO_ON_TICKS)) u_reliso (
    .clock (clock),
    .rst   (rst),
    .tick  (tick),
    .level (blink_reliso)
  );

  // ----------------------------------------------------------------------
  // Lamp selection
  // ----------------------------------------------------------------------
  logic          sw_isolate;
  logic          iso_eff;
  rml_red_mode_t red_mode;
  rml_red_mode_t next_red_mode;
  rml_lamp_t     next_lamp;

  assign iso_eff = cond.isolate | sw_isolate;

  always_comb begin
    // Fixed priority among red conditions
    if (cond.output_active && iso_eff) begin
      next_red_mode = RED_REL_ISO;
    end else if (cond.output_active) begin
      next_red_mode = RED_STEADY;
    end else if (iso_eff) begin
      next_red_mode = RED_ISOLATE;
    end else if (cond.local_trouble) begin
      next_red_mode = RED_TROUBLE;
    end else begin
      next_red_mode = RED_OFF;
    end
    next_lamp.green = cond.power_good;
    next_lamp.amber = cond.malfunction;
    unique case (next_red_mode)
      RED_REL_ISO: next_lamp.red = blink_reliso;
      RED_STEADY:  next_lamp.red = 1'b1;
      RED_ISOLATE: next_lamp.red = blink_iso;
      RED_TROUBLE: next_lamp.red = blink_trouble;
      RED_OFF:     next_lamp.red = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      red_mode <= RED_OFF;
      lamp     <= '0;
    end else begin
      red_mode <= next_red_mode;
      lamp     <= next_lamp;
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  logic        acc;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [31:0] wr_addr;
  logic [31:0] next_wr_addr;
  logic        next_sw_isolate;
  logic        ctrl_now;
  logic [31:0] status_word;
  logic [31:0] next_hrdata;
  logic [31:0] hrdata;

  // Writes of other sizes are ignored: every register is a whole word
  assign acc = ahb_req.hsel && ahb_req.hready
               && ahb_req.htrans == HTRANS_NONSEQ
               && ahb_req.hsize == HSIZE_WORD;

  // Forward a write in its data phase to a read issued right behind it
  assign ctrl_now = (wr_pend && wr_addr == CTRL_OFS)
                    ? ahb_req.hwdata[CTRL_ISO_BIT] : sw_isolate;

  always_comb begin
    status_word = '0;
    status_word[ST_COND_LSB +: 5] = {cond.malfunction, iso_eff,
                                     cond.local_trouble, cond.output_active,
                                     cond.power_good};
    status_word[ST_LAMP_LSB +: 3] = {lamp.amber, lamp.red, lamp.green};
    status_word[ST_MODE_LSB +: 3] = red_mode;
  end

  always_comb begin
    next_wr_pend    = acc && ahb_req.hwrite;
    next_wr_addr    = ahb_req.haddr & ADDR_MASK;
    next_sw_isolate = sw_isolate;
    if (wr_pend && wr_addr == CTRL_OFS) begin
      next_sw_isolate = ahb_req.hwdata[CTRL_ISO_BIT];
    end
    next_hrdata = hrdata;
    if (acc && !ahb_req.hwrite) begin
      // Unmapped addresses read as zero with an OKAY answer
      unique case (ahb_req.haddr & ADDR_MASK)
        CTRL_OFS:   next_hrdata = {31'h0000_0000, ctrl_now};
        STATUS_OFS: next_hrdata = status_word;
        default:    next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend    <= 1'b0;
      wr_addr    <= '0;
      sw_isolate <= CTRL_RESET[CTRL_ISO_BIT];
      hrdata     <= '0;
    end else begin
      wr_pend    <= next_wr_pend;
      wr_addr    <= next_wr_addr;
      sw_isolate <= next_sw_isolate;
      hrdata     <= next_hrdata;
    end
  end

  assign ahb_rsp.hrdata    = hrdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = HRESP_OKAY;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_GREEN_FOLLOWS_POWER: assert property (
    @(posedge clock) disable iff (rst)
    ##1 lamp.green == $past(cond.power_good))
    else $error("green lamp does not follow power");

  AST_RED_STEADY: assert property (
    @(posedge clock) disable iff (rst)
    (cond.output_active && !iso_eff)[*2] |=> lamp.red && $past(lamp.red))
    else $error("red not steady with output active");

  AST_RED_TROUBLE: assert property (
    @(posedge clock) disable iff (rst)
    (cond.local_trouble && !cond.output_active && !iso_eff)
    |=> lamp.red == $past(blink_trouble))
    else $error("red not on trouble pattern");

  AST_RED_ISOLATE: assert property (
    @(posedge clock) disable iff (rst)
    (iso_eff && !cond.output_active) |=> lamp.red == $past(blink_iso))
    else $error("red not on isolate pattern");

  AST_RED_REL_ISO: assert property (
    @(posedge clock) disable iff (rst)
    (iso_eff && cond.output_active) |=> lamp.red == $past(blink_reliso))
    else $error("red not on release-isolate pattern");

  AST_AMBER: assert property (
    @(posedge clock) disable iff (rst)
    ##1 lamp.amber == $past(cond.malfunction))
    else $error("amber lamp does not follow malfunction");

  AST_TICK_SINGLE: assert property (
    @(posedge clock) disable iff (rst)
    (tick && TICK_CYCLES > 1) |=> !tick)
    else $error("blink tick longer than one cycle");

  AST_PRIORITY: assert property (
    @(posedge clock) disable iff (rst)
    (cond.local_trouble && iso_eff) |=> red_mode != RED_TROUBLE)
    else $error("trouble overrode isolate");

  AST_CTRL_WRITE: assert property (
    @(posedge clock) disable iff (rst)
    (wr_pend && wr_addr == CTRL_OFS)
    |=> sw_isolate == $past(ahb_req.hwdata[CTRL_ISO_BIT]))
    else $error("control write not stored");

  COV_REL_ISO: cover property (
    @(posedge clock) disable iff (rst) red_mode == RED_REL_ISO);
  COV_ISOLATE: cover property (
    @(posedge clock) disable iff (rst) red_mode == RED_ISOLATE);
  COV_TROUBLE_BLINK: cover property (
    @(posedge clock) disable iff (rst)
    red_mode == RED_TROUBLE && $fell(lamp.red));
  COV_SW_ISOLATE: cover property (
    @(posedge clock) disable iff (rst) sw_isolate && !cond.isolate);

endmodule : rml_led_driver

// file: include/rml_pkg.sv
// Purpose: Shared constants and types for the release module lamp driver
// Assumes: 40 MHz clock, AHB-Lite register access, 32-bit data
// Notes:   Timing figures kept in their own units, cycle counts derived
package rml_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 25;
  localparam int NS_PER_MS         = 1000000;
  localparam int TICK_MS           = 25;
  localparam int TROUBLE_PERIOD_MS = 250;
  localparam int TROUBLE_ON_MS     = 125;
  localparam int ISO_PERIOD_MS     = 1000;
  localparam int ISO_ON_MS         = 50;
  localparam int RELISO_ON_MS      = 950;
  localparam int TICK_CYCLES_DEF   = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TROUBLE_PER_TICKS = TROUBLE_PERIOD_MS / TICK_MS;
  localparam int TROUBLE_ON_TICKS  = TROUBLE_ON_MS / TICK_MS;
  localparam int ISO_PER_TICKS     = ISO_PERIOD_MS / TICK_MS;
  localparam int ISO_ON_TICKS      = ISO_ON_MS / TICK_MS;
  localparam int RELISO_ON_TICKS   = RELISO_ON_MS / TICK_MS;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] CTRL_OFS     = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS   = 32'h0000_0004;
  localparam logic [31:0] ADDR_MASK    = 32'h0000_00FF;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam int          CTRL_ISO_BIT = 0;
  localparam int          ST_COND_LSB  = 0;
  localparam int          ST_LAMP_LSB  = 8;
  localparam int          ST_MODE_LSB  = 12;

  // ----------------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    RED_OFF, RED_STEADY, RED_TROUBLE, RED_ISOLATE, RED_REL_ISO
  } rml_red_mode_t;

  typedef struct packed {
    logic power_good;
    logic output_active;
    logic local_trouble;
    logic isolate;
    logic malfunction;
  } rml_cond_t;

  typedef struct packed {
    logic green;
    logic red;
    logic amber;
  } rml_lamp_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } rml_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } rml_ahb_rsp_t;

endpackage : rml_pkg

// file: core/rml_blink.sv
// Purpose: Free-running tick counter giving one blink pattern
// Assumes: tick is a one-cycle strobe from the shared divider
// Notes:   Output is registered and changes only on a tick
`timescale 1ns/10ps
module rml_blink #(
  parameter int PERIOD = 10,
  parameter int ON     = 5
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Timebase
  input  wire logic tick,
  // Pattern
  output logic      level
);
  import rml_pkg::*;

  localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_level;

  always_comb begin
    next_cnt = cnt;
    if (tick) begin
      if (cnt == W'(PERIOD - 1)) begin
        next_cnt = '0;
      end else begin
        next_cnt = cnt + W'(1);
      end
    end
    next_level = (next_cnt < W'(ON));
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt   <= '0;
      level <= (ON > 0);
    end else begin
      cnt   <= next_cnt;
      level <= next_level;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_BLINK_WRAP_ON: assert property (
    @(posedge clock) disable iff (rst)
    (tick && cnt == W'(PERIOD - 1)) |=> level)
    else $error("blink not lit at period start");

  AST_BLINK_GOES_DARK: assert property (
    @(posedge clock) disable iff (rst)
    (tick && cnt == W'(ON - 1) && ON < PERIOD) |=> !level)
    else $error("blink lit past its on time");

endmodule : rml_blink

// file: verification/rml_lamp_panel.sv
// Purpose: Front panel lamps, counts lit cycles of the red lamp
// Assumes: Lamp drives are registered levels on clock
// Notes:   Count clears while measure is low
`timescale 1ns/10ps
module rml_lamp_panel (
  // Clock
  input  wire logic               clock,
  // Lamp drives and window
  input  wire rml_pkg::rml_lamp_t lamp,
  input  wire logic               measure,
  // Red lit cycles in window
  output int                      red_on
);
  import rml_pkg::*;
  // Unknown drive counts as dark, so it cannot pass for lit
  always @(posedge clock) begin
    if (!measure) begin
      red_on <= 0;
    end else if (lamp.red === 1'b1) begin
      red_on <= red_on + 1;
    end
  end
endmodule : rml_lamp_panel

// file: verification/rml_led_driver_tb.sv
// Purpose: Self-checking bench for the release module lamp driver
// Assumes: TICK_CYCLES of 4, so one slow period is 160 clocks
// Notes:   Duty checked as lit count over a whole period
`timescale 1ns/10ps
module rml_led_driver_tb;
  import rml_pkg::*;
  localparam int TCK = 4;
  localparam int WIN = ISO_PER_TICKS * TCK;
  logic         clock = 1'b0;
  logic         rst = 1'b1;
  rml_cond_t    cond = '0;
  rml_lamp_t    lamp;
  rml_ahb_req_t mreq = '0;
  rml_ahb_req_t req;
  rml_ahb_rsp_t rsp;
  logic         measure = 1'b0;
  int           red_on;
  int           bad_count = 0;
  int           checked = 0;
  int           cycles = 0;
  int           m;
  logic [31:0]  seed = 32'hA87440C9;
  logic [31:0]  rd;
  logic [5:0]   v;
  // Isolate over trouble, output over trouble: priority gets exercised
  logic [5:0]   tbl [8] = '{6'h1A, 6'h1C, 6'h16, 6'h14, 6'h15, 6'h10,
                            6'h38, 6'h23};
  int on_of [5] = '{0, WIN, TROUBLE_ON_TICKS * TCK * 4,
                    ISO_ON_TICKS * TCK, RELISO_ON_TICKS * TCK};

  always #12.5 clock = ~clock;

  always_comb begin
    req = mreq;
    req.hready = rsp.hreadyout;
  end

  rml_led_driver #(.TICK_CYCLES(TCK)) i_rml_led_driver (
    .clock   (clock),
    .rst     (rst),
    .cond    (cond),
    .lamp    (lamp),
    .ahb_req (req),
    .ahb_rsp (rsp)
  );

  rml_lamp_panel i_rml_lamp_panel (
    .clock   (clock),
    .lamp    (lamp),
    .measure (measure),
    .red_on  (red_on)
  );

  // ------------------------------------------------------------------
  // Model and helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Red priority; bit 5 is the software isolate request
  function automatic int mode_of(input logic [5:0] c);
    if (c[3] && (c[1] | c[5])) return 4;
    if (c[3]) return 1;
    if (c[1] | c[5]) return 3;
    if (c[2]) return 2;
    return 0;
  endfunction : mode_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Single transfer of size sz, waits on hready without assuming latency
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, input logic [2:0] sz);
    @(posedge clock);
    mreq.hsel <= 1'b1;
    mreq.haddr <= a;
    mreq.htrans <= HTRANS_NONSEQ;
    mreq.hwrite <= wr;
    mreq.hsize <= sz;
    do @(posedge clock); while (rsp.hreadyout !== 1'b1);
    mreq.hsel <= 1'b0;
    mreq.htrans <= 2'h0;
    mreq.hwdata <= wd;
    do @(posedge clock); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
    check({31'h0, rsp.hresp}, {31'h0, HRESP_OKAY});
  endtask : bus

  task automatic final_report();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, CTRL_OFS, 32'h0, HSIZE_WORD);
    check(rd, CTRL_RESET);
    bus(1'b1, CTRL_OFS, 32'hFFFFFFFF, HSIZE_WORD);
    bus(1'b0, CTRL_OFS, 32'h0, HSIZE_WORD);
    check(rd, 32'h1);
    // Byte write must leave the control word alone
    bus(1'b1, CTRL_OFS, 32'h0, 3'h0);
    bus(1'b0, CTRL_OFS, 32'h0, HSIZE_WORD);
    check(rd, 32'h1);
    bus(1'b1, 32'h10, 32'hFFFFFFFF, HSIZE_WORD);
    bus(1'b0, 32'h10, 32'h0, HSIZE_WORD);
    check(rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      v = (i < 8) ? tbl[i] : seed[5:0];
      m = mode_of(v);
      bus(1'b1, CTRL_OFS, {31'h0, v[5]}, HSIZE_WORD);
      cond <= v[4:0];
      repeat (3) @(posedge clock);
      check({31'h0, lamp.green}, {31'h0, v[4]});
      check({31'h0, lamp.amber}, {31'h0, v[0]});
      measure <= 1'b1;
      repeat (WIN) @(posedge clock);
      measure <= 1'b0;
      #1;
      check(red_on, on_of[m]);
      bus(1'b0, STATUS_OFS, 32'h0, HSIZE_WORD);
      check(rd & 32'h751F, {17'h0, m[2:0], 1'b0, v[0], 1'b0, v[4], 3'h0,
            v[0], v[1] | v[5], v[2], v[3], v[4]});
    end
    final_report();
  end
endmodule : rml_led_driver_tb
